// >>> src/oatr_pkg.sv
// oatr_pkg: constants shared by the output arbiter and threshold registers
// assumes a 125 MHz system clock and 9-bit register offsets
package oatr_pkg;
    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [8:0]  OFS_HS_DS       = 9'h18A;
    localparam logic [8:0]  OFS_HS_SRC      = 9'h18B;
    localparam logic [8:0]  OFS_LS_DS_A     = 9'h18C;
    localparam logic [8:0]  OFS_LS_DS_B     = 9'h18D;
    localparam logic [8:0]  OFS_BOOST_THR   = 9'h19B;
    localparam logic [8:0]  OFS_BOOST_GRANT = 9'h19C;
    localparam logic [8:0]  OFS_BOOST_FILT  = 9'h19D;

    // -----------------------------------------------------------------
    // sizes and field positions
    // -----------------------------------------------------------------
    localparam int          NCORE      = 4;
    localparam int          NHS        = 5;
    localparam int          NLS        = 6;
    localparam int          NOUT       = 11;
    localparam int          THR_W      = 3;
    localparam int          BOOST_W    = 8;
    localparam int          FLT_LEN_W  = 12;
    localparam int          FLT_POL    = 12;
    localparam int          OC_TRIM_W  = 6;
    localparam int          BS_CNT_W   = 23;

    // -----------------------------------------------------------------
    // reset values and threshold codes
    // -----------------------------------------------------------------
    localparam logic [14:0] RST_THR15   = 15'h0000;
    localparam logic [2:0]  RST_THR3    = 3'h0;
    localparam logic [7:0]  RST_BOOST   = 8'h00;
    localparam logic [3:0]  RST_GRANT   = 4'h0;
    localparam logic [12:0] RST_FILT    = 13'h0000;
    localparam logic [2:0]  SRC_THR_LOW  = 3'h1;
    localparam logic [2:0]  SRC_THR_HIGH = 3'h2;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int BS_TIMER_MS   = 36;
    localparam int BS_TIMER_CYC  = BS_TIMER_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OC_SETTLE_NS  = 40;
    localparam int OC_SETTLE_CYC = (OC_SETTLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    // offset compensation sequencer
    typedef enum logic [1:0] {
        OC_IDLE = 2'b00,
        OC_SET  = 2'b01,
        OC_WAIT = 2'b10,
        OC_DONE = 2'b11
    } oatr_oc_state_t;
endpackage

// >>> src/oatr_regs.sv
// oatr_regs: output arbiter, diagnosis, offset compensation, boost
// filter and drain-source / source threshold registers
// assumes all inputs synchronous to CLK; cores 0..3 are uc0ch1, uc1ch1,
// uc0ch2, uc1ch2; outputs 0..4 are hs1..hs5, 5..10 are ls1..ls6
//
// Contract
// - merge the four cores' output commands into one set for the drivers.
// - start pins, comparator and current feedback go to all cores unchanged.
// - diagnose outputs by comparing merged commands with voltage feedback.
// - on core request, run trim sequence cancelling amplifier input offset.
// - boost threshold written by host and by cores, cores gated by grants.
// - boost limit level is eight bits and drives the boost monitor.
// - each grant bit, active high, lets one core write boost threshold.
// - boost monitor gets end-of-line offset applied without core action.
// - policy 0: a sample against the trend clears the filter counter.
// - policy 1: a sample against the trend decrements the filter counter.
// - twelve-bit debounce sets filter time to clock period times value+1.
// - every drain-source and source threshold is its own three-bit field.
// - core changes a threshold field only with access right to its output.
// - reading source thresholds returns effective, init-masked values.
// - core backdoor writes to boost threshold have no effect.
// - core backdoor filter writes apply only with boost grant held.
// - during bootstrap init source threshold is low, then high at 36 ms.
`timescale 1ns/10ps
`default_nettype none
module oatr_regs
    import oatr_pkg::*;
#(
    parameter int BS_TIMER_CYCLES = oatr_pkg::BS_TIMER_CYC
) (
    input  wire  logic                  CLK,
    input  wire  logic                  NRST,
    input  wire  logic                  SPI_WR,
    input  wire  logic                  SPI_RD,
    input  wire  logic [8:0]            SPI_ADDR,
    input  wire  logic [15:0]           SPI_WDATA,
    output logic       [15:0]           SPI_RDATA,
    input  wire  logic [3:0]            BD_WR,
    input  wire  logic [3:0][7:0]       BD_ADDR,
    input  wire  logic [3:0][15:0]      BD_WDATA,
    input  wire  logic [3:0]            CORE_BOOST_WR,
    input  wire  logic [3:0][7:0]       CORE_BOOST_DATA,
    input  wire  logic [3:0][10:0]      OUTPUT_ACCESS_RIGHTS,
    input  wire  logic [3:0][10:0]      CORE_OUT_CMD,
    output logic       [10:0]           OUT_DRIVE,
    input  wire  logic [10:0]           VDS_FBK,
    output logic       [10:0]           DIAG_FAULT,
    input  wire  logic [5:0]            START_INPUT_PINS,
    input  wire  logic [10:0]           CMP_FBK,
    input  wire  logic [3:0]            CUR_FBK,
    output logic       [3:0][5:0]       CORE_START,
    output logic       [3:0][10:0]      CORE_CMP_FBK,
    output logic       [3:0][3:0]       CORE_CUR_FBK,
    input  wire  logic [3:0]            CORE_OC_REQ,
    input  wire  logic                  AMP_HIGH,
    output logic       [5:0]            OC_TRIM,
    output logic                        OC_BUSY,
    output logic                        OC_DONE,
    input  wire  logic [3:0]            BOOST_EOL_OFFSET,
    output logic       [7:0]            BOOST_DAC_CODE,
    input  wire  logic                  BOOST_CMP,
    output logic                        BOOST_CMP_FILT,
    input  wire  logic                  UV_VCCP,
    input  wire  logic [4:0]            HS_BS_INIT,
    output logic       [14:0]           HS_DS_LEVEL,
    output logic       [14:0]           HS_SRC_LEVEL,
    output logic       [17:0]           LS_DRAIN_SOURCE_LEVEL
);
    import oatr_pkg::*;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // widen five per-output rights into a 15-bit field mask
    function automatic logic [14:0] fmask(input logic [4:0] r);
        logic [14:0] m;
        m = '0;
        for (int i = 0; i < 5; i++) begin
            m[i*THR_W +: THR_W] = {THR_W{r[i]}};
        end
        return m;
    endfunction

    // merge masked new data into an old value
    function automatic logic [14:0] mrg(input logic [14:0] o,
                                        input logic [14:0] n,
                                        input logic [14:0] m);
        return (o & ~m) | (n & m);
    endfunction

    logic [14:0]          hs_ds_q, hs_src_q, ls_a_q;
    logic [2:0]           ls_b_q;
    logic [7:0]           boost_thr_q;
    logic [3:0]           grants_q;
    logic [12:0]          filt_q;
    logic [14:0]          eff_src;
    logic                 bs_done_q;
    logic [BS_CNT_W-1:0]  bs_cnt_q;

    // -----------------------------------------------------------------
    // threshold registers
    // -----------------------------------------------------------------
    // cores in order, host last so a host write wins a same-cycle clash
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            hs_ds_q  <= RST_THR15;
            hs_src_q <= RST_THR15;
            ls_a_q   <= RST_THR15;
            ls_b_q   <= RST_THR3;
        end else begin
            logic [14:0] hd, hsr, la;
            logic [2:0]  lb;
            hd  = hs_ds_q;
            hsr = hs_src_q;
            la  = ls_a_q;
            lb  = ls_b_q;
            for (int c = 0; c < NCORE; c++) begin
                if (BD_WR[c]) begin
                    // per-field access right gating
                    if (BD_ADDR[c] == OFS_HS_DS[7:0])
                        hd = mrg(hd, BD_WDATA[c][14:0],
                                 fmask(OUTPUT_ACCESS_RIGHTS[c][4:0]));
                    if (BD_ADDR[c] == OFS_HS_SRC[7:0])
                        hsr = mrg(hsr, BD_WDATA[c][14:0],
                                  fmask(OUTPUT_ACCESS_RIGHTS[c][4:0]));
                    if (BD_ADDR[c] == OFS_LS_DS_A[7:0])
                        la = mrg(la, BD_WDATA[c][14:0],
                                 fmask(OUTPUT_ACCESS_RIGHTS[c][9:5]));
                    if (BD_ADDR[c] == OFS_LS_DS_B[7:0]
                        && OUTPUT_ACCESS_RIGHTS[c][10])
                        lb = BD_WDATA[c][2:0];
                end
            end
            // host writes all fields, reserved bit dropped
            if (SPI_WR) begin
                if (SPI_ADDR == OFS_HS_DS)   hd  = SPI_WDATA[14:0];
                if (SPI_ADDR == OFS_HS_SRC)  hsr = SPI_WDATA[14:0];
                if (SPI_ADDR == OFS_LS_DS_A) la  = SPI_WDATA[14:0];
                if (SPI_ADDR == OFS_LS_DS_B) lb  = SPI_WDATA[2:0];
            end
            hs_ds_q  <= hd;
            hs_src_q <= hsr;
            ls_a_q   <= la;
            ls_b_q   <= lb;
        end
    end

    // -----------------------------------------------------------------
    // boost threshold, grants and filter setup
    // -----------------------------------------------------------------
    // direct core writes by grant, backdoor path has no entry
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            boost_thr_q <= RST_BOOST;
        end else if (SPI_WR && SPI_ADDR == OFS_BOOST_THR) begin
            boost_thr_q <= SPI_WDATA[BOOST_W-1:0];
        end else begin
            for (int c = 0; c < NCORE; c++) begin
                if (CORE_BOOST_WR[c] && grants_q[c])
                    boost_thr_q <= CORE_BOOST_DATA[c];
            end
        end
    end

    // grants are host-only
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            grants_q <= RST_GRANT;
        end else if (SPI_WR && SPI_ADDR == OFS_BOOST_GRANT) begin
            grants_q <= SPI_WDATA[3:0];
        end
    end

    // filter setup, backdoor needs the core's boost grant
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            filt_q <= RST_FILT;
        end else if (SPI_WR && SPI_ADDR == OFS_BOOST_FILT) begin
            filt_q <= SPI_WDATA[12:0];
        end else begin
            for (int c = 0; c < NCORE; c++) begin
                if (BD_WR[c] && BD_ADDR[c] == OFS_BOOST_FILT[7:0]
                    && grants_q[c])
                    filt_q <= BD_WDATA[c][12:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // bootstrap init timer and effective source thresholds
    // -----------------------------------------------------------------
    // runs once vccp leaves undervoltage, stops at end of count
    always_ff @(posedge CLK) begin
        if (!NRST || UV_VCCP) begin
            bs_cnt_q  <= '0;
            bs_done_q <= 1'b0;
        end else if (!bs_done_q) begin
            bs_cnt_q  <= bs_cnt_q + 1'b1;
            bs_done_q <= (bs_cnt_q == BS_CNT_W'(BS_TIMER_CYCLES - 1));
        end
    end

    // init masking of source thresholds
    always_comb begin
        for (int i = 0; i < NHS; i++) begin
            if (HS_BS_INIT[i])
                eff_src[i*THR_W +: THR_W] = bs_done_q ? SRC_THR_HIGH
                                                      : SRC_THR_LOW;
            else
                eff_src[i*THR_W +: THR_W] = hs_src_q[i*THR_W +: THR_W];
        end
    end

    // -----------------------------------------------------------------
    // register readback
    // -----------------------------------------------------------------
    // one cycle latency, unmapped and reserved bits zero
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            SPI_RDATA <= 16'h0000;
        end else if (SPI_RD) begin
            case (SPI_ADDR)
                OFS_HS_DS:       SPI_RDATA <= {1'b0, hs_ds_q};
                OFS_HS_SRC:      SPI_RDATA <= {1'b0, eff_src};
                OFS_LS_DS_A:     SPI_RDATA <= {1'b0, ls_a_q};
                OFS_LS_DS_B:     SPI_RDATA <= {13'h0000, ls_b_q};
                OFS_BOOST_THR:   SPI_RDATA <= {8'h00, boost_thr_q};
                OFS_BOOST_GRANT: SPI_RDATA <= {12'h000, grants_q};
                OFS_BOOST_FILT:  SPI_RDATA <= {3'h0, filt_q};
                default:         SPI_RDATA <= 16'h0000;
            endcase
        end
    end

    // thresholds to the comparators
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            HS_DS_LEVEL           <= RST_THR15;
            HS_SRC_LEVEL          <= RST_THR15;
            LS_DRAIN_SOURCE_LEVEL <= 18'h00000;
        end else begin
            HS_DS_LEVEL           <= hs_ds_q;
            HS_SRC_LEVEL          <= eff_src;
            LS_DRAIN_SOURCE_LEVEL <= {ls_b_q, ls_a_q};
        end
    end

    // -----------------------------------------------------------------
    // boost monitor level with end-of-line trim
    // -----------------------------------------------------------------
    // signed trim added with saturation, no core involvement
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            BOOST_DAC_CODE <= RST_BOOST;
        end else begin
            logic signed [9:0] s;
            s = $signed({2'b00, boost_thr_q})
                + $signed({{6{BOOST_EOL_OFFSET[3]}}, BOOST_EOL_OFFSET});
            if (s < 0)
                BOOST_DAC_CODE <= 8'h00;
            else if (s > 10'sd255)
                BOOST_DAC_CODE <= 8'hFF;
            else
                BOOST_DAC_CODE <= s[7:0];
        end
    end

    // -----------------------------------------------------------------
    // boost comparator filter
    // -----------------------------------------------------------------
    logic [11:0] flt_cnt_q;
    // counts samples against the filtered state; flips after value+1
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            flt_cnt_q      <= 12'h000;
            BOOST_CMP_FILT <= 1'b0;
        end else if (BOOST_CMP != BOOST_CMP_FILT) begin
            if (flt_cnt_q == filt_q[FLT_LEN_W-1:0]) begin
                BOOST_CMP_FILT <= BOOST_CMP;
                flt_cnt_q      <= 12'h000;
            end else begin
                flt_cnt_q <= flt_cnt_q + 12'h001;
            end
        end else if (!filt_q[FLT_POL]) begin
            flt_cnt_q <= 12'h000;
        end else if (flt_cnt_q != 12'h000) begin
            flt_cnt_q <= flt_cnt_q - 12'h001;
        end
    end

    // -----------------------------------------------------------------
    // output merge, diagnosis, input fan-out
    // -----------------------------------------------------------------
    logic [10:0] merged;
    // each core drives only outputs it holds rights
    always_comb begin
        merged = 11'h000;
        for (int c = 0; c < NCORE; c++) begin
            merged = merged | (CORE_OUT_CMD[c] & OUTPUT_ACCESS_RIGHTS[c]);
        end
    end

    // merged drive, fault when on but drain-source stays high
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            OUT_DRIVE  <= 11'h000;
            DIAG_FAULT <= 11'h000;
        end else begin
            OUT_DRIVE  <= merged;
            DIAG_FAULT <= OUT_DRIVE & VDS_FBK;
        end
    end

    // same inputs to every core, no arbitration
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            CORE_START   <= '0;
            CORE_CMP_FBK <= '0;
            CORE_CUR_FBK <= '0;
        end else begin
            CORE_START   <= {NCORE{START_INPUT_PINS}};
            CORE_CMP_FBK <= {NCORE{CMP_FBK}};
            CORE_CUR_FBK <= {NCORE{CUR_FBK}};
        end
    end

    // -----------------------------------------------------------------
    // offset compensation sequencer
    // -----------------------------------------------------------------
    oatr_oc_state_t oc_q;
    logic [2:0]     oc_bit_q;
    logic [3:0]     oc_wait_q;
    // successive approximation of the trim, msb first
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            oc_q      <= OC_IDLE;
            oc_bit_q  <= 3'h0;
            oc_wait_q <= 4'h0;
            OC_TRIM   <= 6'h00;
        end else begin
            case (oc_q)
                OC_IDLE: if (|CORE_OC_REQ) begin
                    OC_TRIM  <= 6'h00;
                    oc_bit_q <= 3'(OC_TRIM_W - 1);
                    oc_q     <= OC_SET;
                end
                OC_SET: begin
                    OC_TRIM[oc_bit_q] <= 1'b1;
                    oc_wait_q <= 4'(OC_SETTLE_CYC);
                    oc_q      <= OC_WAIT;
                end
                OC_WAIT: begin
                    if (oc_wait_q != 4'h0) begin
                        oc_wait_q <= oc_wait_q - 4'h1;
                    end else begin
                        if (AMP_HIGH) OC_TRIM[oc_bit_q] <= 1'b0;
                        if (oc_bit_q == 3'h0) begin
                            oc_q <= oatr_pkg::OC_DONE;
                        end else begin
                            oc_bit_q <= oc_bit_q - 3'h1;
                            oc_q     <= OC_SET;
                        end
                    end
                end
                oatr_pkg::OC_DONE: oc_q <= OC_IDLE;
                default: oc_q <= OC_IDLE;
            endcase
        end
    end

    assign OC_BUSY = (oc_q != OC_IDLE);
    assign OC_DONE = (oc_q == oatr_pkg::OC_DONE);

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    localparam int OC_MAX = 60;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    a_merge_drive: assert property (
        ##1 OUT_DRIVE == $past(merged))
        else $error("merged drive mismatch");
    a_diag_fault: assert property (
        OUT_DRIVE[0] && VDS_FBK[0] |=> DIAG_FAULT[0])
        else $error("diagnosis missed fault");
    a_oc_bounded: assert property (
        $rose(OC_BUSY) |-> ##[1:OC_MAX] OC_DONE)
        else $error("offset compensation too slow");
    a_boost_nogrant: assert property (
        CORE_BOOST_WR != 4'h0 && (CORE_BOOST_WR & grants_q) == 4'h0
        && !SPI_WR |=> $stable(boost_thr_q))
        else $error("ungranted core changed boost threshold");
    a_boost_bd_none: assert property (
        !SPI_WR && CORE_BOOST_WR == 4'h0 && BD_WR != 4'h0
        |=> $stable(boost_thr_q))
        else $error("backdoor changed boost threshold");
    a_filt_clear: assert property (
        BOOST_CMP == BOOST_CMP_FILT && !filt_q[FLT_POL]
        |=> flt_cnt_q == 12'h000)
        else $error("filter counter not cleared");
    a_filt_decr: assert property (
        BOOST_CMP == BOOST_CMP_FILT && filt_q[FLT_POL]
        && flt_cnt_q != 12'h000 |=> flt_cnt_q == $past(flt_cnt_q) - 12'h001)
        else $error("filter counter not decremented");
    a_filt_flip: assert property (
        $changed(BOOST_CMP_FILT)
        |-> $past(flt_cnt_q) == $past(filt_q[FLT_LEN_W-1:0]))
        else $error("filter flipped early");
    a_src_readback: assert property (
        SPI_RD && SPI_ADDR == OFS_HS_SRC |=> SPI_RDATA == {1'b0, $past(eff_src)})
        else $error("source readback not effective value");
    a_bs_level: assert property (
        HS_BS_INIT[0] |-> eff_src[2:0] == (bs_done_q ? SRC_THR_HIGH
                                                     : SRC_THR_LOW))
        else $error("init source threshold wrong");
    a_resv_zero: assert property (
        SPI_RD && SPI_ADDR == OFS_LS_DS_B |=> SPI_RDATA[15:3] == 13'h0000)
        else $error("reserved bits not zero");

    c_filt_flip: cover property ($changed(BOOST_CMP_FILT));
    c_oc_done:   cover property (OC_DONE);
    c_bd_thr:    cover property (BD_WR[1] && BD_ADDR[1] == OFS_HS_DS[7:0]);
    c_bs_high:   cover property (HS_BS_INIT[0] && bs_done_q);
endmodule
`default_nettype wire

// >>> sim/oatr_core_model.sv
// oatr_core_model: the four microcode cores facing the register block
// assumes the bench calls its tasks; changes signals at falling CLK edges
`timescale 1ns/10ps
`default_nettype none
module oatr_core_model (
    input  wire logic             clk,
    output logic [3:0]            bd_wr,
    output logic [3:0][7:0]       bd_addr,
    output logic [3:0][15:0]      bd_wdata,
    output logic [3:0]            boost_wr,
    output logic [3:0][7:0]       boost_data,
    output logic [3:0][10:0]      rights,
    output logic [3:0][10:0]      cmd,
    output logic [3:0]            oc_req
);
    // cores idle: no strobes, no rights, no commands
    initial begin
        {bd_wr, bd_addr, bd_wdata, boost_wr, boost_data} = '0;
        {rights, cmd, oc_req} = '0;
    end
    // one core's rights, command set and trim request
    task automatic set_core(input int c, input logic [10:0] r,
                            input logic [10:0] cm, input logic oc);
        @(negedge clk);
        rights[c] = r;
        cmd[c] = cm;
        oc_req[c] = oc;
    endtask
    // backdoor write: one-cycle pulse, then bus shows inverted data
    task automatic bd_write(input int c, input logic [7:0] a,
                            input logic [15:0] d);
        @(negedge clk);
        {bd_wr[c], bd_addr[c], bd_wdata[c]} = {1'b1, a, d};
        @(negedge clk);
        {bd_wr[c], bd_addr[c], bd_wdata[c]} = {1'b0, ~a, ~d};
    endtask
    // direct boost threshold write pulse
    task automatic boost_write(input int c, input logic [7:0] v);
        @(negedge clk);
        {boost_wr[c], boost_data[c]} = {1'b1, v};
        @(negedge clk);
        {boost_wr[c], boost_data[c]} = {1'b0, ~v};
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// tb_top: self-checking bench for the threshold register block
// assumes oatr_regs and oatr_core_model; inputs change at falling edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import oatr_pkg::*;
    logic CLK = 0, NRST = 0, SPI_WR = 0, SPI_RD = 0, AMP_HIGH = 0;
    logic BOOST_CMP = 0, UV_VCCP = 1, OC_BUSY, OC_DONE, BOOST_CMP_FILT;
    logic [8:0] SPI_ADDR = '0;
    logic [15:0] SPI_WDATA = '0, SPI_RDATA;
    logic [10:0] VDS_FBK = '0, CMP_FBK = '0, OUT_DRIVE, DIAG_FAULT;
    logic [5:0] START_INPUT_PINS = '0, OC_TRIM;
    logic [3:0] CUR_FBK = '0, BOOST_EOL_OFFSET = '0;
    logic [4:0] HS_BS_INIT = '0;
    logic [3:0] BD_WR, CORE_BOOST_WR, CORE_OC_REQ;
    logic [3:0][7:0] BD_ADDR, CORE_BOOST_DATA;
    logic [3:0][15:0] BD_WDATA;
    logic [3:0][10:0] OUTPUT_ACCESS_RIGHTS, CORE_OUT_CMD, CORE_CMP_FBK;
    logic [3:0][5:0] CORE_START;
    logic [3:0][3:0] CORE_CUR_FBK;
    logic [7:0] BOOST_DAC_CODE;
    logic [14:0] HS_DS_LEVEL, HS_SRC_LEVEL;
    logic [17:0] LS_DRAIN_SOURCE_LEVEL;
    int n_fail = 0, compares = 0, cyc = 0;
    // ------------------------------------------------------------
    // clock, block and cores
    // ------------------------------------------------------------
    always #4 CLK = ~CLK;
    // amplifier model: over-compensated above trim 2C
    always @(negedge CLK) AMP_HIGH <= (OC_TRIM > 6'h2C);
    oatr_regs #(.BS_TIMER_CYCLES(20)) dut_u (.*);
    oatr_core_model core_u (.clk(CLK), .bd_wr(BD_WR), .bd_addr(BD_ADDR),
        .bd_wdata(BD_WDATA), .boost_wr(CORE_BOOST_WR),
        .boost_data(CORE_BOOST_DATA), .rights(OUTPUT_ACCESS_RIGHTS),
        .cmd(CORE_OUT_CMD), .oc_req(CORE_OC_REQ));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        compares++;
        if (e !== g) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic spi_wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge CLK);
        {SPI_WR, SPI_ADDR, SPI_WDATA} = {1'b1, a, d};
        @(negedge CLK);
        {SPI_WR, SPI_WDATA} = {1'b0, ~d};
    endtask
    task automatic spi_rd(input logic [8:0] a, input logic [15:0] e);
        @(negedge CLK);
        {SPI_RD, SPI_ADDR} = {1'b1, a};
        @(negedge CLK);
        SPI_RD = 1'b0;
        chk($sformatf("reg %h", a), e, SPI_RDATA);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [8:0] a [7] = '{OFS_HS_DS, OFS_HS_SRC, OFS_LS_DS_A,
            OFS_LS_DS_B, OFS_BOOST_THR, OFS_BOOST_GRANT, OFS_BOOST_FILT};
        logic [15:0] e [7] = '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h0007,
            16'h00FF, 16'h000F, 16'h1FFF};
        spi_rd(9'h100, 16'h0000);
        foreach (a[i]) spi_rd(a[i], 16'h0000);
        foreach (a[i]) spi_wr(a[i], 16'hFFFF);
        foreach (a[i]) spi_rd(a[i], e[i]);
        chk("ls lvl", 16'hFFFF, LS_DRAIN_SOURCE_LEVEL[17:2]);
        chk("ds lvl", 16'h7FFF, {1'b0, HS_DS_LEVEL});
        foreach (a[i]) spi_wr(a[i], 16'h0000);
        $display("test registers done");
    endtask
    task automatic t_grant();
        core_u.boost_write(1, 8'h5A);
        spi_rd(OFS_BOOST_THR, 16'h0000);
        spi_wr(OFS_BOOST_GRANT, 16'h0002);
        core_u.boost_write(1, 8'h5A);
        spi_rd(OFS_BOOST_THR, 16'h005A);
        BOOST_EOL_OFFSET = 4'h2;
        repeat (2) @(negedge CLK);
        chk("dac code", 16'h005C, {8'h00, BOOST_DAC_CODE});
        core_u.bd_write(1, 8'h9B, 16'h0011);
        spi_rd(OFS_BOOST_THR, 16'h005A);
        core_u.bd_write(1, 8'h9D, 16'h0003);
        core_u.bd_write(0, 8'h9D, 16'h0005);
        spi_rd(OFS_BOOST_FILT, 16'h0003);
        core_u.set_core(0, 11'h001, 11'h000, 1'b0);
        core_u.bd_write(0, 8'h8A, 16'h7FFF);
        core_u.bd_write(0, 8'h8D, 16'h0007);
        spi_rd(OFS_HS_DS, 16'h0007);
        spi_rd(OFS_LS_DS_B, 16'h0000);
        $display("test access rights done");
    endtask
    task automatic t_route();
        core_u.set_core(2, 11'h7FF, 11'h401, 1'b0);
        core_u.set_core(3, 11'h000, 11'h002, 1'b0);
        {VDS_FBK, START_INPUT_PINS} = {11'h003, 6'h2A};
        {CMP_FBK, CUR_FBK} = {11'h155, 4'h9};
        repeat (3) @(negedge CLK);
        chk("drive", 16'h0401, {5'h00, OUT_DRIVE});
        chk("fault", 16'h0001, {5'h00, DIAG_FAULT});
        chk("start", 16'h002A, {10'h000, CORE_START[3]});
        chk("cmp", 16'h0155, {5'h00, CORE_CMP_FBK[0]});
        chk("cur", 16'h0009, {12'h000, CORE_CUR_FBK[1]});
        $display("test routing done");
    endtask
    task automatic t_boot();
        {HS_BS_INIT, UV_VCCP} = {5'h1F, 1'b0};
        spi_rd(OFS_HS_SRC, 16'h1249);
        repeat (25) @(negedge CLK);
        spi_rd(OFS_HS_SRC, 16'h2492);
        chk("src lvl", 16'h2492, {1'b0, HS_SRC_LEVEL});
        {HS_BS_INIT, UV_VCCP} = {5'h00, 1'b1};
        $display("test bootstrap done");
    endtask
    task automatic t_filter(input logic pol);
        logic [7:0] pat = 8'b0011_0111;
        spi_wr(OFS_BOOST_FILT, {3'h0, pol, 12'h003});
        for (int i = 0; i < 8; i++) begin
            BOOST_CMP = pat[i];
            @(negedge CLK);
        end
        chk("filter", {15'h0, pol}, {15'h0, BOOST_CMP_FILT});
        $display("test filter done");
    endtask
    task automatic t_offset();
        int n = 0;
        core_u.set_core(3, 11'h000, 11'h000, 1'b1);
        while (OC_DONE !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        chk("busy", 16'h0001, {15'h0, OC_BUSY});
        chk("trim", 16'h002C, {10'h000, OC_TRIM});
        core_u.set_core(3, 11'h000, 11'h000, 1'b0);
        $display("test offset done");
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(negedge CLK);
        NRST = 1'b1;
        t_regs();
        t_grant();
        t_route();
        t_boot();
        t_filter(1'b0);
        t_filter(1'b1);
        t_offset();
        conclude();
    end
endmodule
`default_nettype wire
